// ### common/xbar_regs.vh
// Contract
// [RULE1] seventeen pins: two byte ports, one bit
// [RULE2] only pins 0.0 to 1.7 take functions
// [RULE3] port read always returns real pin level
// [RULE4] functions ranked, uart highest, allocated by rank
// [RULE5] function gets lowest free unskipped pin
// [RULE6] uart fixed on pins 0.4 and 0.5
// [RULE7] comparator outputs fixed on 1.4, 1.5
// [RULE8] pins given to higher rank are passed over
// [RULE9] skipped pins treated as already taken
// [RULE10] software skips pins used outside the matrix
// [RULE11] skip mask 0x0C shifts allocation past crystal
// [RULE12] special signals never routed, only skipped
// [RULE13] per-pin push-pull or open-drain select
// [RULE14] two select words hold function enables; code reads word a only and ignores word b
// [RULE15] matrix disabled: all pins inputs, drivers off
// [RULE16] smbus and uart always take both pins
// [RULE17] spi takes three or four pins by mode
// [RULE18] unclaimed pins act as plain port io
// [RULE19] order spi, smbus, sysclk; recomputed continuously
// [RULE20] function without free pin stays unrouted
`ifndef XBAR_REGS_VH
`define XBAR_REGS_VH

`define XB_NUM_PINS 17
`define XB_NUM_ELIG 16
`define XB_NUM_FUNC 11
`define XB_CODE_W 4

// function codes, also the priority order for allocated ones
`define XB_F_UTX 4'h0
`define XB_F_URX 4'h1
`define XB_F_SCK 4'h2
`define XB_F_MISO 4'h3
`define XB_F_MOSI 4'h4
`define XB_F_NSS 4'h5
`define XB_F_SDA 4'h6
`define XB_F_SCL 4'h7
`define XB_F_SYSCLK 4'h8
`define XB_F_CMPA 4'h9
`define XB_F_CMP 4'hA
`define XB_F_NONE 4'hF

// first and last allocated function code
`define XB_ALLOC_FIRST 2
`define XB_ALLOC_LAST 8

// fixed pin positions
`define XB_PIN_UTX 4
`define XB_PIN_URX 5
`define XB_PIN_CMPA 12
`define XB_PIN_CMP 13

// select word a bit positions
`define XB_SEL_UART 0
`define XB_SEL_SPI 1
`define XB_SEL_SMB 2
`define XB_SEL_SYSCLK 3
`define XB_SEL_CMP 4
`define XB_SEL_CMPA 5

`define XB_SKIP_RESET 8'h00
`define XB_MODE_RESET 8'h00

`endif

// ### logic/pin_driver.v
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// one pin output stage, registered
// ----------------------------------------
module pin_driver (
  input wire clk_i,
  input wire nrst_i,
  input wire enable_i,
  input wire routed_i,
  input wire func_out_i,
  input wire func_drive_i,
  input wire force_od_i,
  input wire gpio_out_i,
  input wire push_pull_i,
  output reg pin_out_o,
  output reg pin_oe_n_o
);
  reg src_val;
  reg src_drv;
  reg od;
  reg next_out;
  reg next_oe_n;

  always @* begin
    src_val = routed_i ? func_out_i : gpio_out_i; // [RULE18]
    src_drv = routed_i ? func_drive_i : 1'b1;
    od = force_od_i | ~push_pull_i; // [RULE13]
    next_out = src_val;
    next_oe_n = 1'b1;
    if (enable_i && src_drv) begin // [RULE15]
      if (od) begin
        // open-drain only pulls low, the pin floats high
        next_out = 1'b0;
        next_oe_n = src_val;
      end else begin
        next_oe_n = 1'b0;
      end
    end
  end

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_out_o <= 1'b0;
      pin_oe_n_o <= 1'b1;
    end else begin
      pin_out_o <= next_out;
      pin_oe_n_o <= next_oe_n;
    end
  end
endmodule // pin_driver
`default_nettype wire

// ### logic/priority_crossbar_port_mux.v
`timescale 1ns/1ps
`default_nettype none
`include "xbar_regs.vh"
module priority_crossbar_port_mux #(
  parameter NUM_PINS = `XB_NUM_PINS,
  parameter NUM_ELIG = `XB_NUM_ELIG,
  parameter NUM_FUNC = `XB_NUM_FUNC
) (
  input wire clk_i,
  input wire nrst_i,
  input wire matrix_enable_i,
  input wire [7:0] function_select_a_i,
  input wire [7:0] function_select_b_i,
  input wire slave_select_mode_i,
  input wire [7:0] port0_skip_mask_i,
  input wire [7:0] port1_skip_mask_i,
  input wire [7:0] output_drive_select0_i,
  input wire [7:0] output_drive_select1_i,
  input wire output_drive_select2_i,
  input wire [NUM_PINS-1:0] gpio_out_i,
  input wire [NUM_FUNC-1:0] func_out_i,
  input wire [NUM_FUNC-1:0] func_drive_i,
  input wire [NUM_PINS-1:0] pin_in_i,
  output wire [NUM_PINS-1:0] pin_out_o,
  output wire [NUM_PINS-1:0] pin_oe_n_o,
  output reg [NUM_PINS-1:0] port_read_o,
  output reg [NUM_FUNC-1:0] func_in_o,
  output reg [NUM_FUNC-1:0] func_routed_o
);
  // ----------------------------------------
  // allocation
  // ----------------------------------------
  reg [NUM_PINS*4-1:0] map;
  reg [NUM_PINS*4-1:0] next_map;
  reg [NUM_PINS-1:0] taken;
  reg [NUM_FUNC-1:0] req;
  reg found;
  integer p;
  integer s;

  // select word b is not used; the matrix enable comes in on a separate port
  wire unused_b = |function_select_b_i;

  always @* begin
    next_map = {NUM_PINS{`XB_F_NONE}};
    req = {NUM_FUNC{1'b0}};
    found = 1'b0;
    // pin of port two never takes a function
    taken = {1'b1, port1_skip_mask_i, port0_skip_mask_i}; // [RULE2] [RULE9] [RULE11] [RULE12]
    if (function_select_a_i[`XB_SEL_UART]) begin // [RULE14]
      next_map[`XB_PIN_UTX*4 +: 4] = `XB_F_UTX; // [RULE6] [RULE16]
      next_map[`XB_PIN_URX*4 +: 4] = `XB_F_URX; // [RULE6]
      taken[`XB_PIN_UTX] = 1'b1;
      taken[`XB_PIN_URX] = 1'b1;
    end
    if (function_select_a_i[`XB_SEL_CMPA]) begin
      next_map[`XB_PIN_CMPA*4 +: 4] = `XB_F_CMPA; // [RULE7]
      taken[`XB_PIN_CMPA] = 1'b1;
    end
    if (function_select_a_i[`XB_SEL_CMP]) begin
      next_map[`XB_PIN_CMP*4 +: 4] = `XB_F_CMP; // [RULE7]
      taken[`XB_PIN_CMP] = 1'b1;
    end
    if (function_select_a_i[`XB_SEL_SPI]) begin
      req[`XB_F_SCK] = 1'b1; // [RULE17]
      req[`XB_F_MISO] = 1'b1;
      req[`XB_F_MOSI] = 1'b1;
      req[`XB_F_NSS] = slave_select_mode_i; // [RULE17]
    end
    if (function_select_a_i[`XB_SEL_SMB]) begin
      req[`XB_F_SDA] = 1'b1; // [RULE16]
      req[`XB_F_SCL] = 1'b1;
    end
    req[`XB_F_SYSCLK] = function_select_a_i[`XB_SEL_SYSCLK];
    // codes walked in rank order, each takes the lowest free pin
    for (s = `XB_ALLOC_FIRST; s <= `XB_ALLOC_LAST; s = s + 1) begin // [RULE4] [RULE19]
      found = 1'b0;
      if (req[s]) begin
        for (p = 0; p < NUM_ELIG; p = p + 1) begin
          if (!found && !taken[p]) begin // [RULE5] [RULE8]
            next_map[p*4 +: 4] = s[3:0];
            taken[p] = 1'b1;
            found = 1'b1;
          end
        end
      end
    end
  end

  // recomputed every cycle so any enable or skip change takes effect
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      map <= {NUM_PINS{`XB_F_NONE}};
    end else begin
      map <= next_map; // [RULE19]
    end
  end

  // ----------------------------------------
  // inputs back to peripherals
  // ----------------------------------------
  reg [NUM_FUNC-1:0] next_func_in;
  reg [NUM_FUNC-1:0] next_routed;
  integer q;

  always @* begin
    // unrouted inputs idle high, matching a released line
    next_func_in = {NUM_FUNC{1'b1}};
    next_routed = {NUM_FUNC{1'b0}};
    for (q = 0; q < NUM_PINS; q = q + 1) begin
      if (matrix_enable_i && map[q*4 +: 4] != `XB_F_NONE) begin
        next_func_in[map[q*4 +: 4]] = pin_in_i[q];
        next_routed[map[q*4 +: 4]] = 1'b1;
      end
    end
  end

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      port_read_o <= {NUM_PINS{1'b0}};
      func_in_o <= {NUM_FUNC{1'b1}};
      func_routed_o <= {NUM_FUNC{1'b0}};
    end else begin
      port_read_o <= pin_in_i; // [RULE3]
      func_in_o <= next_func_in; // [RULE20]
      func_routed_o <= next_routed; // [RULE20]
    end
  end

  // ----------------------------------------
  // pin output stages
  // ----------------------------------------
  wire [NUM_PINS-1:0] push_pull = {output_drive_select2_i, output_drive_select1_i,
                                   output_drive_select0_i};

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g = g + 1) begin : g_pin // [RULE1]
      wire [3:0] code = map[g*4 +: 4];
      wire routed = code != `XB_F_NONE;
      wire fo = routed ? func_out_i[code] : 1'b0;
      wire fd = routed ? func_drive_i[code] : 1'b0; // [RULE20]
      // smbus lines are open-drain whatever the mode bit says
      wire smb = code == `XB_F_SDA || code == `XB_F_SCL;
      pin_driver u_drv (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .enable_i(matrix_enable_i),
        .routed_i(routed),
        .func_out_i(fo),
        .func_drive_i(fd),
        .force_od_i(smb),
        .gpio_out_i(gpio_out_i[g]),
        .push_pull_i(push_pull[g]),
        .pin_out_o(pin_out_o[g]),
        .pin_oe_n_o(pin_oe_n_o[g])
      );
    end
  endgenerate
endmodule // priority_crossbar_port_mux
`default_nettype wire

// ### verification/priority_crossbar_port_mux_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// --
// crossbar port checks
// --
module priority_crossbar_port_mux_monitor (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic matrix_enable_i,
  input wire logic [7:0] function_select_a_i,
  input wire logic slave_select_mode_i,
  input wire logic [7:0] port0_skip_mask_i,
  input wire logic output_drive_select2_i,
  input wire logic [16:0] gpio_out_i,
  input wire logic [10:0] func_out_i,
  input wire logic [16:0] pin_in_i,
  input wire logic [16:0] pin_out_o,
  input wire logic [16:0] pin_oe_n_o,
  input wire logic [16:0] port_read_o,
  input wire logic [10:0] func_in_o,
  input wire logic [10:0] func_routed_o
);
  // level on the wire in either drive mode, so mode changes cannot mask a bad route
  wire logic [16:0] lvl = pin_oe_n_o | pin_out_o;
  wire logic en = matrix_enable_i;
  wire logic [7:0] sel = function_select_a_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  off_drive_a: assert property (
    !en [*2] |=> &pin_oe_n_o && &func_in_o && !func_routed_o) else $error("active while off");
  port_read_a: assert property (
    $past(nrst_i) |-> port_read_o == $past(pin_in_i)) else $error("port read wrong");
  uart_fixed_a: assert property (
    (en && sel[0]) [*2] |=> lvl[4] == $past(func_out_i[0]) && func_in_o[1] == $past(pin_in_i[5]))
    else $error("uart pins wrong");
  cmp_fixed_a: assert property (
    (en && sel[5:4] == 2'h3) [*2] |=> lvl[13:12] == $past(func_out_i[10:9]))
    else $error("comparator pins wrong");
  gpio_mode_a: assert property (
    (en && $stable(output_drive_select2_i)) [*2] |=> {pin_out_o[16], pin_oe_n_o[16]} ==
    ($past(output_drive_select2_i) ? {$past(gpio_out_i[16]), 1'b0} : {1'b0, $past(gpio_out_i[16])}))
    else $error("port two drive wrong");
  spi_alloc_a: assert property (
    (en && sel[3:0] == 4'h2 && port0_skip_mask_i == 8'h00) [*2] |=>
    &func_routed_o[4:2] && lvl[2:0] == $past(func_out_i[4:2])) else $error("spi pins wrong");
  // pins 0, 1, 6 and 7 free leave room for all four spi lines, else select may go unrouted
  nss_mode_a: assert property (
    (en && sel[1] && $stable(slave_select_mode_i) &&
     (port0_skip_mask_i & 8'hC3) == 8'h00) [*2] |=>
    func_routed_o[5] == $past(slave_select_mode_i)) else $error("select routing wrong");
  skip_shift_a: assert property (
    (en && sel[1:0] == 2'h3 && port0_skip_mask_i == 8'h0C) [*2] |=>
    lvl[6] == $past(func_out_i[4])) else $error("skip shift wrong");
  cover property (en && sel[0]);
  cover property (en && port0_skip_mask_i == 8'h0C);
  cover property (!en ##1 en);
endmodule // priority_crossbar_port_mux_monitor
`default_nettype wire

// ### verification/pin_world.sv
`timescale 1ns/1ps
`default_nettype none
// --
// board side of the pins
// --
module pin_world (
  input wire logic [16:0] pin_out_i,
  input wire logic [16:0] pin_oe_n_i,
  input wire logic [16:0] ext_i,
  output logic [16:0] pin_level_o
);
  // released pins show the board's level, never the last driven one
  assign pin_level_o = (pin_out_i & ~pin_oe_n_i) | (ext_i & pin_oe_n_i);
endmodule // pin_world
`default_nettype wire

// ### verification/priority_crossbar_port_mux_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module priority_crossbar_port_mux_tb_top;
  logic clk_i = 0, nrst_i = 0, en = 0, ssm = 0, m2 = 0;
  logic [7:0] sel = 0, sk0 = 0, sk1 = 0, m0 = 0, m1 = 0;
  logic [16:0] gpo = 0, ext = 0, pin_in, pout, poe_n, prd;
  logic [10:0] fo = 0, fin, frt;
  logic [19:0] exp_q[$], e;
  integer seed = 32'hCDAC, fail_count = 0, compares = 0;
  event settle;
  // --
  // rows: enable, select, nss mode, skips, expected routing, mosi pin
  // --
  logic [51:0] row [0:7] = '{52'h0_3F_1_00_00_000_1F, 52'h1_02_1_00_00_03C_02,
    52'h1_02_0_00_00_01C_02, 52'h1_03_1_0C_00_03F_06, 52'h1_0F_1_FF_00_1FF_0A,
    52'h1_37_0_0C_00_6DF_06, 52'h1_08_0_FF_FF_000_1F, 52'h1_0E_1_00_00_1FC_02};
  always #2.5 clk_i = ~clk_i;
  task automatic cmp_map(input logic [10:0] x, input logic [10:0] y);
    compares++;
    if (x !== y) begin
      fail_count++;
      $display("MISMATCH %0t exp %h got %h", $time, x, y);
    end
  endtask
  task automatic cmp_lvl(input logic x, input logic y);
    compares++;
    if (x !== y) begin
      fail_count++;
      $display("MISMATCH %0t exp %h got %h", $time, x, y);
    end
  endtask
  task automatic print_verdict;
    if (fail_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic run(input logic [51:0] r);
    @(negedge clk_i);
    en = r[48];
    sel = r[47:40];
    ssm = r[36];
    {sk0, sk1} = r[35:20];
    {m0, m1, fo} = 27'($random(seed));
    repeat (5) @(negedge clk_i) begin
      {m2, gpo} = 18'($random(seed));
      ext = 17'($random(seed));
    end
    exp_q.push_back({fo[4], r[18:0]});
    -> settle;
  endtask
  always @(settle) begin
    e = exp_q.pop_front();
    cmp_map(e[18:8], frt);
    if (e[7:0] < 17) cmp_lvl(e[19], poe_n[e[4:0]] | pout[e[4:0]]);
  end
  initial begin
    repeat (10) @(posedge clk_i);
    @(negedge clk_i) nrst_i = 1;
    foreach (row[i]) run(row[i]);
    @(negedge clk_i) nrst_i = 0;
    @(negedge clk_i) nrst_i = 1;
    run(row[3]);
    @(negedge clk_i);
    print_verdict;
  end
  // run needs under 100 cycles, so 500 means a hang
  initial begin
    repeat (500) @(posedge clk_i);
    fail_count++;
    print_verdict;
  end
  pin_world u_world (.pin_out_i(pout), .pin_oe_n_i(poe_n), .ext_i(ext), .pin_level_o(pin_in));
  priority_crossbar_port_mux u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .matrix_enable_i(en),
    .function_select_a_i(sel), .function_select_b_i(8'h00), .slave_select_mode_i(ssm),
    .port0_skip_mask_i(sk0), .port1_skip_mask_i(sk1), .output_drive_select0_i(m0),
    .output_drive_select1_i(m1), .output_drive_select2_i(m2), .gpio_out_i(gpo),
    .func_out_i(fo), .func_drive_i(11'h7FF), .pin_in_i(pin_in), .pin_out_o(pout),
    .pin_oe_n_o(poe_n), .port_read_o(prd), .func_in_o(fin), .func_routed_o(frt));
endmodule // priority_crossbar_port_mux_tb_top
bind priority_crossbar_port_mux priority_crossbar_port_mux_monitor u_mon (.clk_i(clk_i),
  .nrst_i(nrst_i), .matrix_enable_i(matrix_enable_i),
  .function_select_a_i(function_select_a_i), .slave_select_mode_i(slave_select_mode_i),
  .port0_skip_mask_i(port0_skip_mask_i), .output_drive_select2_i(output_drive_select2_i),
  .gpio_out_i(gpio_out_i), .func_out_i(func_out_i), .pin_in_i(pin_in_i),
  .pin_out_o(pin_out_o), .pin_oe_n_o(pin_oe_n_o), .port_read_o(port_read_o),
  .func_in_o(func_in_o), .func_routed_o(func_routed_o));
`default_nettype wire
